// ### comp_offset_calc.sv
/*
  Piecewise-linear compensation offset in 30 mV steps, two's complement,
  zero at 20 degrees, clamped beyond -40 and 80 degrees.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
module comp_offset_calc
  import lcd_temp_comp_pkg::*;
(
  input  wire logic [7:0]        tempCode,
  input  wire logic [2:0]        slopeSel0,
  input  wire logic [2:0]        slopeSel1,
  input  wire logic [2:0]        slopeSel2,
  input  wire logic [2:0]        slopeSel3,
  output logic signed [7:0]      offsetCode
);

  // One code is 15/16 degree, one step is 30 mV, so steps = dcode * sf / 32.
  // Magnitude is truncated so a partial step never shows.
  function automatic logic signed [7:0] steps(input logic [5:0] dcode,
                                               input logic signed [6:0] sf);
    logic [6:0]  mag;
    logic [12:0] prod;
    logic [7:0]  q;
    mag  = sf[6] ? 7'(-sf) : 7'(sf);
    prod = 13'(dcode) * 13'(mag);
    q    = 8'(prod >> STEP_SHIFT);
    return sf[6] ? 8'(-q) : 8'(q);
  endfunction

  logic signed [6:0] sf0, sf1, sf2, sf3;

  always_comb begin
    sf0 = slope_factor(slopeSel0);
    sf1 = slope_factor(slopeSel1);
    sf2 = slope_factor(slopeSel2);
    sf3 = slope_factor(slopeSel3);
    // Four equal 30 degree regions around 20 degrees.
    if (tempCode >= TEMP_CODE_80C) begin
      offsetCode = steps(REGION_SPAN, sf3) + steps(REGION_SPAN, sf2);
    end else if (tempCode > TEMP_CODE_50C) begin
      offsetCode = steps(6'(tempCode - TEMP_CODE_50C), sf3)
                 + steps(REGION_SPAN, sf2);
    end else if (tempCode > TEMP_CODE_20C) begin
      offsetCode = steps(6'(tempCode - TEMP_CODE_20C), sf2);
    end else if (tempCode > TEMP_CODE_M10C) begin
      offsetCode = steps(6'(TEMP_CODE_20C - tempCode), sf1);
    end else begin
      // Code 0 is -40 degrees, so the clamp below it falls out naturally.
      offsetCode = steps(6'(TEMP_CODE_M10C - tempCode), sf0)
                 + steps(REGION_SPAN, sf1);
    end
  end

endmodule
`default_nettype wire

// ### lcd_temp_comp.sv
/*
  Temperature readout, jitter filter, compensation offset, saturated target
  voltage code and voltage selector configuration, behind an APB slave.
  Assumes an analog sensor that converts while sensorRun is high and presents
  a stable code on sensorCode by the end of the conversion time.
*/
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Temperature read back as 8-bit code
// - Code scale 0.9375 degrees, offset -40
// - Measure repeatedly while enabled, 5 ms each
// - Interval derived from system clock
// - Filter suppresses single-LSB jitter
// - Filter starts at 20 degrees after reset
// - Filter enable selects filtered, reset off
// - Compensation only when enable bit set
// - Four equal regions, own slope each
// - Slope code table, default zero
// - Offset quantised in 30 mV steps
// - Piecewise offset formulas per region
// - Offset clamped beyond 80 and -40
// - Code plus offset saturates, never wraps
// - Selector follows bias and mux settings
// - Bias levels 3, 4, 5; static 2
// - Backplanes 1, 2, 4, 6, 8
// - Offset two's complement, zero at 20
// - Target is prog code plus offset
// - Target limited to 9.0 V
module lcd_temp_comp
  import lcd_temp_comp_pkg::*;
#(
  parameter int unsigned CONV_CNT     = CONV_CYCLES,
  parameter int unsigned INTERVAL_CNT = INTERVAL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire apb_req_type apbReq,
  output apb_rsp_type      apbRsp,
  input  wire logic [7:0]  sensorCode,
  output logic             sensorRun,
  output logic [7:0]       targetCode,
  output logic [3:0]       activeBackplanes,
  output logic [2:0]       biasLevels,
  output logic [7:0]       backplaneEnable
);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_CONVERT = 3'b010,
    ST_WAIT    = 3'b100
  } meas_state_type;

  // Sensor synchroniser. The code is only sampled at the end of a
  // conversion, long after it settled, so per-bit skew cannot tear it.
  logic [7:0] sensorMeta_q, sensorSync_q;

  always_ff @(posedge clk) begin
    sensorMeta_q <= sensorCode;
    sensorSync_q <= sensorMeta_q;
  end

  // Configuration registers.
  logic          measEnable_q, measEnable_d;
  logic          filtEnable_q, filtEnable_d;
  logic          compEnable_q, compEnable_d;
  bias_mode_type biasMode_q, biasMode_d;
  mux_mode_type  muxMode_q, muxMode_d;
  logic [2:0]    slopeSel_q [4];
  logic [2:0]    slopeSel_d [4];
  logic [7:0]    progCode_q, progCode_d;

  // APB slave: one wait cycle, then pready with the answer.
  apb_rsp_type rsp_q, rsp_d;
  logic        accessPhase;
  logic        wrStrobe;
  logic        addrHit;

  assign accessPhase = apbReq.psel && apbReq.penable;
  assign wrStrobe    = accessPhase && rsp_q.pready && apbReq.pwrite;

  // Measurement sequencer.
  meas_state_type state_q, state_d;
  logic [31:0]    timer_q, timer_d;
  logic           runOut_q, runOut_d;
  logic [7:0]     rawTemp_q, rawTemp_d;
  logic [7:0]     filtTemp_q, filtTemp_d;
  logic [7:0]     tempCode_q, tempCode_d;
  logic signed [7:0] compOffset_q, compOffset_d;
  logic [7:0]     target_q, target_d;
  logic [7:0]     newRaw, newFilt, compTemp;
  logic signed [7:0] calcOffset;
  logic           convDone;

  // Filtered value moves halfway toward raw, but only when they differ by
  // more than one code, so a toggling LSB never moves the output.
  function automatic logic [7:0] filter_step(input logic [7:0] filt,
                                             input logic [7:0] raw);
    logic [7:0] diff;
    diff = (raw > filt) ? 8'(raw - filt) : 8'(filt - raw);
    if (diff <= 8'h01) begin
      return filt;
    end
    return (raw > filt) ? 8'(filt + (diff >> 1)) : 8'(filt - (diff >> 1));
  endfunction

  // Saturating add of an unsigned code and a signed offset, capped at 9 V.
  function automatic logic [7:0] sat_target(input logic [7:0] prog,
                                            input logic signed [7:0] off);
    logic signed [9:0] sum;
    sum = $signed({2'b00, prog}) + 10'(off);
    if (sum < 0) begin
      return 8'h00;
    end else if (sum > $signed({2'b00, VMAX_CODE})) begin
      return VMAX_CODE;
    end
    return sum[7:0];
  endfunction

  assign convDone = (state_q == ST_CONVERT) && (timer_q == 32'(CONV_CNT - 1));
  assign newRaw   = sensorSync_q;
  assign newFilt  = filter_step(filtTemp_q, newRaw);
  assign compTemp = filtEnable_q ? newFilt : newRaw;

  comp_offset_calc comp_offset_calc_i (
    .tempCode   (compTemp),
    .slopeSel0  (slopeSel_q[0]),
    .slopeSel1  (slopeSel_q[1]),
    .slopeSel2  (slopeSel_q[2]),
    .slopeSel3  (slopeSel_q[3]),
    .offsetCode (calcOffset)
  );

  always_comb begin
    state_d      = state_q;
    timer_d      = timer_q;
    runOut_d     = 1'b0;
    rawTemp_d    = rawTemp_q;
    filtTemp_d   = filtTemp_q;
    tempCode_d   = tempCode_q;
    compOffset_d = compOffset_q;
    unique case (state_q)
      ST_IDLE: begin
        timer_d = 32'h0000_0000;
        if (measEnable_q) begin
          state_d  = ST_CONVERT;
          runOut_d = 1'b1;
        end
      end
      ST_CONVERT: begin
        runOut_d = 1'b1;
        timer_d  = 32'(timer_q + 32'h0000_0001);
        if (convDone) begin
          // Readout and offset change in the same edge.
          rawTemp_d    = newRaw;
          filtTemp_d   = newFilt;
          tempCode_d   = compTemp;
          compOffset_d = calcOffset;
          runOut_d     = 1'b0;
          timer_d      = 32'h0000_0000;
          state_d      = ST_WAIT;
        end
      end
      ST_WAIT: begin
        timer_d = 32'(timer_q + 32'h0000_0001);
        if (!measEnable_q) begin
          state_d = ST_IDLE;
        end else if (timer_q == 32'(INTERVAL_CNT - 1)) begin
          timer_d  = 32'h0000_0000;
          runOut_d = 1'b1;
          state_d  = ST_CONVERT;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!compEnable_q) begin
      compOffset_d = 8'sh00;
    end
    target_d = sat_target(progCode_q, compOffset_d);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      timer_q      <= 32'h0000_0000;
      runOut_q     <= 1'b0;
      rawTemp_q    <= TEMP_CODE_20C;
      filtTemp_q   <= TEMP_CODE_20C;
      tempCode_q   <= TEMP_CODE_20C;
      compOffset_q <= 8'sh00;
      target_q     <= PROG_RST;
    end else begin
      state_q      <= state_d;
      timer_q      <= timer_d;
      runOut_q     <= runOut_d;
      rawTemp_q    <= rawTemp_d;
      filtTemp_q   <= filtTemp_d;
      tempCode_q   <= tempCode_d;
      compOffset_q <= compOffset_d;
      target_q     <= target_d;
    end
  end

  // Register writes take effect at the edge where pready is sampled high.
  always_comb begin
    measEnable_d = measEnable_q;
    filtEnable_d = filtEnable_q;
    compEnable_d = compEnable_q;
    biasMode_d   = biasMode_q;
    muxMode_d    = muxMode_q;
    progCode_d   = progCode_q;
    for (int i = 0; i < 4; i++) begin
      slopeSel_d[i] = slopeSel_q[i];
    end
    if (wrStrobe) begin
      unique case (apbReq.paddr)
        ADDR_CTRL: begin
          measEnable_d = apbReq.pwdata[CTRL_MEAS_BIT];
          filtEnable_d = apbReq.pwdata[CTRL_FILT_BIT];
          compEnable_d = apbReq.pwdata[CTRL_COMP_BIT];
          biasMode_d   = bias_mode_type'(apbReq.pwdata[CTRL_BIAS_LSB +: 2]);
          muxMode_d    = mux_mode_type'(apbReq.pwdata[CTRL_MUX_LSB +: 3]);
        end
        ADDR_SLOPE: begin
          for (int i = 0; i < 4; i++) begin
            slopeSel_d[i] = apbReq.pwdata[i * SLOPE_STRIDE +: 3];
          end
        end
        ADDR_PROG: begin
          progCode_d = apbReq.pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    addrHit = (apbReq.paddr == ADDR_CTRL) || (apbReq.paddr == ADDR_SLOPE) ||
              (apbReq.paddr == ADDR_PROG) || (apbReq.paddr == ADDR_TEMP) ||
              (apbReq.paddr == ADDR_COMP) || (apbReq.paddr == ADDR_SEL);
    rsp_d = '0;
    if (accessPhase && !rsp_q.pready) begin
      rsp_d.pready  = 1'b1;
      rsp_d.pslverr = !addrHit;
      if (!apbReq.pwrite) begin
        unique case (apbReq.paddr)
          ADDR_CTRL: begin
            rsp_d.prdata[CTRL_MEAS_BIT]      = measEnable_q;
            rsp_d.prdata[CTRL_FILT_BIT]      = filtEnable_q;
            rsp_d.prdata[CTRL_COMP_BIT]      = compEnable_q;
            rsp_d.prdata[CTRL_BIAS_LSB +: 2] = biasMode_q;
            rsp_d.prdata[CTRL_MUX_LSB +: 3]  = muxMode_q;
          end
          ADDR_SLOPE: begin
            for (int i = 0; i < 4; i++) begin
              rsp_d.prdata[i * SLOPE_STRIDE +: 3] = slopeSel_q[i];
            end
          end
          ADDR_PROG: begin
            rsp_d.prdata[7:0] = progCode_q;
          end
          ADDR_TEMP: begin
            rsp_d.prdata[7:0] = tempCode_q;
          end
          ADDR_COMP: begin
            rsp_d.prdata[7:0]              = compOffset_q;
            rsp_d.prdata[COMP_TGT_LSB +: 8] = target_q;
          end
          ADDR_SEL: begin
            rsp_d.prdata[3:0]               = activeBackplanes;
            rsp_d.prdata[SEL_LVL_LSB +: 3]  = biasLevels;
            rsp_d.prdata[SEL_BUSY_BIT]      = runOut_q;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Voltage selector decode from the two mode settings.
  logic [3:0] planes_d;
  logic [2:0] levels_d;
  logic [7:0] bpEn_d;
  logic [3:0] planes_q;
  logic [2:0] levels_q;
  logic [7:0] bpEn_q;

  always_comb begin
    unique case (muxMode_q)
      MUX_STATIC: planes_d = 4'h1;
      MUX_1_2:    planes_d = 4'h2;
      MUX_1_4:    planes_d = 4'h4;
      MUX_1_6:    planes_d = 4'h6;
      default:    planes_d = 4'h8;
    endcase
    if (muxMode_q == MUX_STATIC) begin
      levels_d = 3'h2;
    end else begin
      unique case (biasMode_q)
        BIAS_HALF:  levels_d = 3'h3;
        BIAS_THIRD: levels_d = 3'h4;
        default:    levels_d = 3'h5;
      endcase
    end
    // Outputs above the active count repeat lower planes, except in 1:6
    // where the top two pins serve as segments.
    bpEn_d = (muxMode_q == MUX_1_6) ? 8'h3F : 8'hFF;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      measEnable_q <= 1'b0;
      filtEnable_q <= 1'b0;
      compEnable_q <= 1'b0;
      biasMode_q   <= BIAS_HALF;
      muxMode_q    <= MUX_STATIC;
      progCode_q   <= PROG_RST;
      for (int i = 0; i < 4; i++) begin
        slopeSel_q[i] <= 3'h0;
      end
      rsp_q        <= '0;
      planes_q     <= 4'h1;
      levels_q     <= 3'h2;
      bpEn_q       <= 8'hFF;
    end else begin
      measEnable_q <= measEnable_d;
      filtEnable_q <= filtEnable_d;
      compEnable_q <= compEnable_d;
      biasMode_q   <= biasMode_d;
      muxMode_q    <= muxMode_d;
      progCode_q   <= progCode_d;
      for (int i = 0; i < 4; i++) begin
        slopeSel_q[i] <= slopeSel_d[i];
      end
      rsp_q        <= rsp_d;
      planes_q     <= planes_d;
      levels_q     <= levels_d;
      bpEn_q       <= bpEn_d;
    end
  end

  assign apbRsp           = rsp_q;
  assign sensorRun        = runOut_q;
  assign targetCode       = target_q;
  assign activeBackplanes = planes_q;
  assign biasLevels       = levels_q;
  assign backplaneEnable  = bpEn_q;

endmodule
`default_nettype wire

// ### lcd_temp_comp_bench.sv
/*
  Self-checking bench for lcd_temp_comp: APB tasks, sensor stimulus, expected offsets.
  Assumes short conversion and interval counts set through the parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module lcd_temp_comp_bench;
  import lcd_temp_comp_pkg::*;
  localparam int unsigned CONV = 8;
  localparam int unsigned GAP  = 20;
  logic        clk, rst, sensorRun, err;
  apb_req_type apbReq;
  apb_rsp_type apbRsp;
  logic [7:0]  sensorCode, targetCode, backplaneEnable, f;
  logic [3:0]  activeBackplanes;
  logic [2:0]  biasLevels;
  logic [31:0] rd;
  int          errorCnt, checkCount, off, tgt, n;
  int          sfTab [8] = '{0, -4, -8, -16, -40, 4, 8, 16};
  int          bpTab [8] = '{1, 2, 4, 6, 8, 8, 8, 8};
  logic [15:0] slv [8] = '{16'h7634, 16'h7634, 16'h7634, 16'h7634,
                           16'h0521, 16'h0521, 16'h0521, 16'h0521};
  int          prv [8] = '{48, 48, 48, 192, 100, 100, 100, 100};
  int          cdv [8] = '{0, 48, 80, 255, 73, 27, 64, 112};

  lcd_temp_comp #(.CONV_CNT(CONV), .INTERVAL_CNT(GAP)) lcd_temp_comp_i (
    .clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .sensorCode(sensorCode),
    .sensorRun(sensorRun), .targetCode(targetCode), .activeBackplanes(activeBackplanes),
    .biasLevels(biasLevels), .backplaneEnable(backplaneEnable));

  always #50 clk = ~clk;

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The request stands until pready is seen high at a rising edge; the answer
  // is taken at that same edge, and only then is the request released.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (apbRsp.pready !== 1'b1 && k < 20);
    if (apbRsp.pready !== 1'b1) begin
      errorCnt++;
      printVerdict();
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    check(nm, rd & m, e);
  endtask

  task automatic setSensor(input logic [7:0] c);
    @(posedge clk);
    sensorCode <= c;
  endtask

  // Skips a conversion already running so the next one sees settled inputs.
  task automatic waitConv();
    int k;
    k = 0;
    while (sensorRun === 1'b1 && k < 100) begin @(negedge clk); k++; end
    while (sensorRun !== 1'b1 && k < 100) begin @(negedge clk); k++; end
    while (sensorRun === 1'b1 && k < 100) begin @(negedge clk); k++; end
    if (k >= 100) begin
      errorCnt++;
      printVerdict();
    end
    repeat (2) @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    apbReq = '0;
    sensorCode = 8'h40;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdChk("ctrl", ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk("slope", ADDR_SLOPE, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk("temp", ADDR_TEMP, 32'h0000_00FF, 32'h0000_0040);
    rdChk("comp", ADDR_COMP, 32'h0000_FFFF, 32'h0000_0000);
    rdChk("sel", ADDR_SEL, 32'h0001_070F, 32'h0000_0201);
    apb(8'h18, 1'b0, 32'h0000_0000);
    check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(ADDR_TEMP, 1'b1, 32'h0000_0055);
    rdChk("temp ro", ADDR_TEMP, 32'h0000_00FF, 32'h0000_0040);
    for (int m = 0; m < 8; m++) begin
      for (int b = 0; b < 4; b++) begin
        apb(ADDR_CTRL, 1'b1, 32'((m << 8) | (b << 4)));
        n = (m == 0) ? 2 : (b == 3) ? 5 : b + 3;
        rdChk("sel", ADDR_SEL, 32'h0001_070F, 32'((n << 8) | bpTab[m]));
        check("backplanes", 32'(activeBackplanes), 32'(bpTab[m]));
        check("levels", 32'(biasLevels), 32'(n));
        check("bp enable", 32'(backplaneEnable), (m == 3) ? 32'h3F : 32'hFF);
      end
    end
    apb(ADDR_CTRL, 1'b1, 32'h0000_0005);
    for (int i = 0; i < 8; i++) begin
      setSensor(cdv[i]);
      apb(ADDR_SLOPE, 1'b1, {16'h0000, slv[i]});
      apb(ADDR_PROG, 1'b1, 32'(prv[i]));
      waitConv();
      off = sfTab[slv[i][2:0]];
      n = sfTab[slv[i][6:4]];
      tgt = sfTab[slv[i][10:8]];
      if (cdv[i] >= 128) off = sfTab[slv[i][14:12]] + tgt;
      else if (cdv[i] > 96) off = (cdv[i] - 96) * sfTab[slv[i][14:12]] / 32 + tgt;
      else if (cdv[i] > 64) off = (cdv[i] - 64) * tgt / 32;
      else if (cdv[i] >= 32) off = (64 - cdv[i]) * n / 32;
      else off = (32 - cdv[i]) * off / 32 + n;
      tgt = prv[i] + off;
      tgt = (tgt < 0) ? 0 : (tgt > 200) ? 200 : tgt;
      rdChk("temp raw", ADDR_TEMP, 32'h0000_00FF, 32'(cdv[i]));
      rdChk("comp", ADDR_COMP, 32'h0000_FFFF, {16'h0, tgt[7:0], off[7:0]});
      check("target", 32'(targetCode), 32'(tgt));
    end
    apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
    rdChk("comp off", ADDR_COMP, 32'h0000_FFFF, 32'h0000_6400);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0003);
    setSensor(8'h60);
    repeat (12) waitConv();
    apb(ADDR_TEMP, 1'b0, 32'h0000_0000);
    f = rd[7:0];
    check("filter settle", 32'(f >= 8'h5F && f <= 8'h61), 32'h1);
    setSensor(f + 8'h01);
    repeat (2) waitConv();
    rdChk("filter up", ADDR_TEMP, 32'h0000_00FF, {24'h0, f});
    setSensor(f - 8'h01);
    repeat (2) waitConv();
    rdChk("filter down", ADDR_TEMP, 32'h0000_00FF, {24'h0, f});
    setSensor(8'h20);
    waitConv();
    apb(ADDR_TEMP, 1'b0, 32'h0000_0000);
    check("filter move", 32'(rd[7:0] > 8'h20 && rd[7:0] < f), 32'h1);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
    waitConv();
    rdChk("filter off", ADDR_TEMP, 32'h0000_00FF, 32'h0000_0020);
    apb(ADDR_CTRL, 1'b1, 32'h0000_0000);
    n = 0;
    for (int i = 0; i < 3 * GAP + 20; i++) begin
      @(negedge clk);
      if (i > 12 && sensorRun !== 1'b0) n++;
    end
    check("run stops", 32'(n), 32'h0);
    printVerdict();
  end
endmodule

bind lcd_temp_comp lcd_temp_comp_properties #(
  .CONV_CNT(CONV_CNT),
  .INTERVAL_CNT(INTERVAL_CNT)
) lcd_temp_comp_properties_i (
  .clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .sensorCode(sensorCode),
  .sensorRun(sensorRun), .targetCode(targetCode), .activeBackplanes(activeBackplanes),
  .biasLevels(biasLevels), .backplaneEnable(backplaneEnable));
`default_nettype wire

// ### lcd_temp_comp_pkg.sv
/*
  Shared constants and types for the LCD temperature readout and voltage
  compensation block: APB register map, field positions, reset values,
  temperature breakpoints, timing constants and the bus carrier structs.
  Assumes a single 10 MHz system clock.
*/
package lcd_temp_comp_pkg;

  // Clock rate and the timing derived from it.
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned CONV_TIME_US     = 5000;
  localparam int unsigned CONV_CYCLES      = (CLK_HZ / 1_000_000) * CONV_TIME_US;
  localparam int unsigned MEAS_INTERVAL_MS = 1000;
  localparam int unsigned INTERVAL_CYCLES  = (CLK_HZ / 1000) * MEAS_INTERVAL_MS;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_SLOPE = 8'h04;
  localparam logic [7:0] ADDR_PROG  = 8'h08;
  localparam logic [7:0] ADDR_TEMP  = 8'h0C;
  localparam logic [7:0] ADDR_COMP  = 8'h10;
  localparam logic [7:0] ADDR_SEL   = 8'h14;

  // Control, slope, comp and selector register field positions.
  localparam int CTRL_MEAS_BIT = 0;
  localparam int CTRL_FILT_BIT = 1;
  localparam int CTRL_COMP_BIT = 2;
  localparam int CTRL_BIAS_LSB = 4;
  localparam int CTRL_MUX_LSB  = 8;
  localparam int SLOPE_STRIDE  = 4;
  localparam int COMP_TGT_LSB  = 8;
  localparam int SEL_LVL_LSB   = 8;
  localparam int SEL_BUSY_BIT  = 16;

  // Temperature codes: T = 0.9375 * code - 40, so 32 codes span 30 degrees.
  localparam logic [7:0] TEMP_CODE_M10C = 8'h20;
  localparam logic [7:0] TEMP_CODE_20C  = 8'h40;
  localparam logic [7:0] TEMP_CODE_50C  = 8'h60;
  localparam logic [7:0] TEMP_CODE_80C  = 8'h80;
  localparam logic [5:0] REGION_SPAN    = 6'h20;
  localparam int         STEP_SHIFT     = 5;

  // Voltage codes: V = code * 0.03 + 3, so 9.0 V is code 200.
  localparam logic [7:0] VMAX_CODE = 8'hC8;
  localparam logic [7:0] PROG_RST  = 8'h00;

  typedef enum logic [2:0] {
    MUX_STATIC = 3'h0,
    MUX_1_2    = 3'h1,
    MUX_1_4    = 3'h2,
    MUX_1_6    = 3'h3,
    MUX_1_8    = 3'h4
  } mux_mode_type;

  typedef enum logic [1:0] {
    BIAS_HALF    = 2'h0,
    BIAS_THIRD   = 2'h1,
    BIAS_QUARTER = 2'h2
  } bias_mode_type;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  // Slope code to slope factor in mV per degree.
  function automatic logic signed [6:0] slope_factor(input logic [2:0] sel);
    logic signed [6:0] sf;
    unique case (sel)
      3'h0:    sf = 7'sd0;
      3'h1:    sf = -7'sd4;
      3'h2:    sf = -7'sd8;
      3'h3:    sf = -7'sd16;
      3'h4:    sf = -7'sd40;
      3'h5:    sf = 7'sd4;
      3'h6:    sf = 7'sd8;
      default: sf = 7'sd16;
    endcase
    return sf;
  endfunction

endpackage

// ### lcd_temp_comp_properties.sv
/*
  Port-level checks for the LCD temperature compensation block.
  Assumes it is bound to lcd_temp_comp and that the master only uses aligned addresses.
*/
`timescale 1ns/1ns
`default_nettype none
module lcd_temp_comp_properties
  import lcd_temp_comp_pkg::*;
#(
  parameter int unsigned CONV_CNT     = 8,
  parameter int unsigned INTERVAL_CNT = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire apb_req_type apbReq,
  input wire apb_rsp_type apbRsp,
  input wire logic [7:0]  sensorCode,
  input wire logic        sensorRun,
  input wire logic [7:0]  targetCode,
  input wire logic [3:0]  activeBackplanes,
  input wire logic [2:0]  biasLevels,
  input wire logic [7:0]  backplaneEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic        wrDone;
  logic [10:0] ctrl_q, ctrl_d;
  logic [7:0]  prog_q, prog_d;
  logic [1:0]  skip_q, skip_d;
  logic [31:0] runCnt_q, runCnt_d, gapCnt_q, gapCnt_d;
  logic        fell_q, fell_d;

  function automatic logic [3:0] bpOf(input logic [2:0] m);
    case (m)
      3'h0: return 4'h1;
      3'h1: return 4'h2;
      3'h2: return 4'h4;
      3'h3: return 4'h6;
      default: return 4'h8;
    endcase
  endfunction

  function automatic logic [2:0] lvlOf(input logic [10:0] c);
    if (c[10:8] == 3'h0) return 3'h2;
    if (c[5:4] == 2'h0) return 3'h3;
    if (c[5:4] == 2'h1) return 3'h4;
    return 3'h5;
  endfunction

  assign wrDone = apbReq.psel & apbReq.penable & apbReq.pwrite & apbRsp.pready;

  // Selector outputs and the nocomp target are only compared two cycles after any write, since they lag the register.
  always_comb begin
    ctrl_d = ctrl_q;
    prog_d = prog_q;
    skip_d = {skip_q[0], 1'b0};
    if (wrDone) begin
      skip_d = 2'h3;
      if (apbReq.paddr == ADDR_CTRL) ctrl_d = apbReq.pwdata[10:0];
      if (apbReq.paddr == ADDR_PROG) prog_d = apbReq.pwdata[7:0];
    end
    runCnt_d = sensorRun ? runCnt_q + 32'h1 : 32'h0;
    gapCnt_d = sensorRun ? 32'h0 : gapCnt_q + 32'h1;
    fell_d = fell_q | (runCnt_q != 32'h0 && !sensorRun);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= '0;
      prog_q <= '0;
      skip_q <= '0;
      runCnt_q <= '0;
      gapCnt_q <= '0;
      fell_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prog_q <= prog_d;
      skip_q <= skip_d;
      runCnt_q <= runCnt_d;
      gapCnt_q <= gapCnt_d;
      fell_q <= fell_d;
    end
  end

  property p_ready_wait;
    apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");

  property p_ready_pulse;
    apbRsp.pready |=> !apbRsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

  property p_err_map;
    apbRsp.pready |-> apbRsp.pslverr == (apbReq.paddr > ADDR_SEL);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong");

  property p_rsp_idle;
    !apbRsp.pready |-> apbRsp.prdata == 32'h0000_0000 && !apbRsp.pslverr;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle) else $error("response outside pready");

  property p_run_len;
    $fell(sensorRun) |-> runCnt_q == CONV_CNT;
  endproperty
  a_run_len: assert property (p_run_len) else $error("conversion length");

  property p_gap_len;
    $rose(sensorRun) && fell_q |-> gapCnt_q >= INTERVAL_CNT;
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("interval too short");

  property p_backplanes;
    skip_q == 2'h0 |-> activeBackplanes == bpOf(ctrl_q[10:8]);
  endproperty
  a_backplanes: assert property (p_backplanes) else $error("backplanes");

  property p_levels;
    skip_q == 2'h0 |-> biasLevels == lvlOf(ctrl_q);
  endproperty
  a_levels: assert property (p_levels) else $error("bias levels");

  property p_bp_enable;
    skip_q == 2'h0 |-> backplaneEnable == ((ctrl_q[10:8] == 3'h3) ? 8'h3F : 8'hFF);
  endproperty
  a_bp_enable: assert property (p_bp_enable) else $error("backplane enable");

  property p_target_max;
    targetCode <= VMAX_CODE;
  endproperty
  a_target_max: assert property (p_target_max) else $error("target above limit");

  property p_target_nocomp;
    skip_q == 2'h0 && !ctrl_q[2] |-> targetCode == ((prog_q > VMAX_CODE) ? VMAX_CODE : prog_q);
  endproperty
  a_target_nocomp: assert property (p_target_nocomp) else $error("target offset");
endmodule
`default_nettype wire
